// ===== ssr_backend_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_backend_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush_req,
    input wire logic diag_run,
    input wire logic [2:0] diag_code,
    output logic flush_done,
    output logic diag_done,
    output logic [2:0] diag_result
);
    logic [3:0] fcnt;
    logic [3:0] dcnt;
    // cache flush and self-test take a few cycles each, never zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fcnt <= 4'h0;
            dcnt <= 4'h0;
        end else begin
            fcnt <= flush_req ? 4'h5 : (fcnt != 4'h0 ? fcnt - 4'h1 : 4'h0);
            dcnt <= diag_run ? 4'h7 : (dcnt != 4'h0 ? dcnt - 4'h1 : 4'h0);
        end
    end
    assign flush_done = (fcnt == 4'h1);
    assign diag_done = (dcnt == 4'h1);
    // inverted outside the done cycle so stale results fail
    assign diag_result = diag_done ? diag_code : ~diag_code;
endmodule
`default_nettype wire

// ===== ssr_pkg.sv
// Contract
// - sector register holds starting sector; chs values run one to sectors per track
// - lba mode: sector register is address bits 0-7, rewritten at command end
// - 48-bit: latest write is bits 0-7, earlier write is bits 24-31
// - status is updated on every detected error and every command completion
// - status read with interrupt pending acknowledges and clears that interrupt
// - while busy other status bits are invalid; any register read returns status
// - ready low during power-up; after command error low until status read
// - fault and corrected-data flags always zero; service flag unsupported
// - seek-complete clears before seek, sets when settled, frozen after error
// - seek-complete set when entering or resting in standby or sleep
// - index flag pulses once per revolution; not meant for host timing
// - error flag set when previous command failed, cleared when next arrives
// - three resets: power-on diagnoses, link also soft resets, soft on bit clear
// - link and soft abort after cache flush; power-on alone inits and stops timer (host abort goes out with the flush request)
// - any reset loads defaults: sector 01h, status 50h, diagnostic code in error
// - power-on reverts parameters; link and soft revert only when enabled by CCh
// - link or soft reset moves sleep to standby; other modes stay
// - power-on spins up to idle unless power-up-in-standby keeps standby
// - every reset and execute-diagnostic runs self-test and posts the code
// - codes: 01h ok, 02h formatter, 03h buffer, 04h ecc, 05h processor
// - alternate status equals status but its read never acknowledges interrupts
package ssr_pkg;
    // ****************************************
    // register selects
    // ****************************************
    localparam logic [2:0] RA_ERROR = 3'h1;
    localparam logic [2:0] RA_SECT = 3'h3;
    localparam logic [2:0] RA_ALT = 3'h6;
    localparam logic [2:0] RA_DEVCTL = 3'h6;
    localparam logic [2:0] RA_STAT = 3'h7;
    // ****************************************
    // field positions
    // ****************************************
    localparam int DC_HOB = 7;
    localparam int DC_SOFT_RESET_BIT = 2;
    localparam int DC_NIEN = 1;
    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [7:0] SECT_RST = 8'h01;
    localparam logic [7:0] STAT_RST = 8'h50;
    localparam logic [7:0] DIAG_OK = 8'h01;
    localparam logic [7:0] DIAG_FMT = 8'h02;
    localparam logic [7:0] DIAG_BUF = 8'h03;
    localparam logic [7:0] DIAG_ECC = 8'h04;
    localparam logic [7:0] DIAG_CPU = 8'h05;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SOFT_RESET_BIT_MIN_PS = 5000000;
    localparam int SOFT_RESET_BIT_MIN_CYC = (SOFT_RESET_BIT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [10:0] SOFT_RESET_BIT_MIN_CNT = 11'(SOFT_RESET_BIT_MIN_CYC);
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {PM_ACTIVE, PM_IDLE, PM_STANDBY, PM_SLEEP} ssr_pwr_e;
    typedef enum logic [2:0] {RS_POR, RS_FLUSH, RS_DIAG, RS_RUN} ssr_rst_e;
endpackage

// ===== ssr_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } ssr_sync_s;
    ssr_sync_s r_reg;
    ssr_sync_s r_next;
    // ****************************************
    // three stages; output moves once stages two and three agree
    // ****************************************
    always_comb begin
        r_next = r_reg;
        r_next.s1 = din;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        if (r_reg.s2 == r_reg.s3) begin
            r_next.q = r_reg.s3;
        end
    end
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
    assign dout = r_reg.q;
endmodule
`default_nettype wire

// ===== ssr_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_top (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic INTRQ,
    input wire logic CMD_START,
    input wire logic CMD_DONE,
    input wire logic CMD_FAIL,
    input wire logic [7:0] CMD_ERR_CODE,
    input wire logic CMD_ERR,
    input wire logic CMD_LBA,
    input wire logic CMD_EXT48,
    input wire logic [7:0] ADDR_LO,
    input wire logic [7:0] ADDR_HI,
    input wire logic SEEK_START,
    input wire logic SEEK_SETTLED,
    input wire logic DRQ_IN,
    input wire logic INDEX_PIN,
    input wire logic LINK_RESET,
    input wire logic DIAG_CMD,
    input wire logic DIAG_DONE,
    input wire logic [2:0] DIAG_RESULT,
    input wire logic FLUSH_DONE,
    input wire logic REVERT_EN,
    input wire logic PUIS_STRAP,
    input wire logic PWR_REQ,
    input wire logic [1:0] PWR_REQ_MODE,
    output logic FLUSH_REQ,
    output logic HOST_ABORT,
    output logic DEV_ABORT,
    output logic HW_INIT,
    output logic DIAG_RUN,
    output logic TIMER_DISABLE,
    output logic PARAM_REVERT,
    output logic SPIN_UP,
    output logic LOAD_DEFAULTS,
    output logic [1:0] PWR_MODE
);
    typedef struct packed {
        ssr_pkg::ssr_rst_e rs;
        ssr_pkg::ssr_pwr_e pm;
        logic [7:0] sect_cur;
        logic [7:0] sect_prev;
        logic [7:0] err_reg;
        logic hob;
        logic soft_reset_bit;
        logic nien;
        logic [10:0] soft_reset_bit_cnt;
        logic link_prev;
        logic busy_cmd;
        logic ready;
        logic ready_hold;
        logic err;
        logic dsc_live;
        logic dsc_shown;
        logic dsc_hold;
        logic data_request_flag;
        logic idx;
        logic int_pend;
        logic intrq;
        logic [7:0] rdata;
        logic flush_req;
        logic host_abort;
        logic dev_abort;
        logic hw_init;
        logic diag_run;
        logic tmr_dis;
        logic revert;
        logic spin_up;
        logic load_dflt;
    } ssr_state_s;

    ssr_state_s r_reg;
    ssr_state_s r_next;
    logic index_sync;
    logic link_sync;

    // ****************************************
    // pin synchronisers
    // ****************************************
    ssr_sync3 u_idx_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .din(INDEX_PIN),
        .dout(index_sync)
    );
    ssr_sync3 u_link_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .din(LINK_RESET),
        .dout(link_sync)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        logic busy;
        logic [7:0] stat;
        logic stat_rd;
        logic soft_go;
        logic link_go;
        busy = 1'b0;
        stat = 8'h00;
        stat_rd = 1'b0;
        soft_go = 1'b0;
        link_go = 1'b0;
        r_next = r_reg;
        // single-cycle strobes drop by default
        r_next.flush_req = 1'b0;
        r_next.host_abort = 1'b0;
        r_next.dev_abort = 1'b0;
        r_next.hw_init = 1'b0;
        r_next.diag_run = 1'b0;
        r_next.tmr_dis = 1'b0;
        r_next.revert = 1'b0;
        r_next.spin_up = 1'b0;
        r_next.load_dflt = 1'b0;
        // soft_reset_bit held high keeps the device busy as well
        busy = r_reg.busy_cmd | r_reg.soft_reset_bit | (r_reg.rs != ssr_pkg::RS_RUN);
        // fault and corrected-data bits are wired low
        stat = {busy, r_reg.ready, 1'b0, r_reg.dsc_shown,
                r_reg.data_request_flag, 1'b0, r_reg.idx, r_reg.err};
        // live inputs sampled every cycle
        r_next.data_request_flag = DRQ_IN;
        r_next.idx = index_sync;

        // host reads; busy forces status onto every select
        if (REG_RD) begin
            if (busy) begin
                r_next.rdata = stat;
            end else begin
                case (REG_ADDR)
                    ssr_pkg::RA_SECT: r_next.rdata = r_reg.hob ? r_reg.sect_prev
                                                                : r_reg.sect_cur;
                    ssr_pkg::RA_ERROR: r_next.rdata = r_reg.err_reg;
                    ssr_pkg::RA_STAT: r_next.rdata = stat;
                    ssr_pkg::RA_ALT: r_next.rdata = stat;
                    default: r_next.rdata = 8'h00;
                endcase
            end
            stat_rd = (REG_ADDR == ssr_pkg::RA_STAT);
        end
        // status read: acknowledge, then release the error holds
        if (stat_rd) begin
            r_next.int_pend = 1'b0;
            r_next.dsc_hold = 1'b0;
            if (r_reg.ready_hold) begin
                r_next.ready_hold = 1'b0;
                r_next.ready = 1'b1;
            end
        end

        // host writes; sector register is a two-deep byte stack
        if (REG_WR && REG_ADDR == ssr_pkg::RA_SECT && !busy) begin
            r_next.sect_prev = r_reg.sect_cur;
            r_next.sect_cur = REG_WDATA;
        end
        if (REG_WR && REG_ADDR == ssr_pkg::RA_DEVCTL) begin
            r_next.hob = REG_WDATA[ssr_pkg::DC_HOB];
            r_next.soft_reset_bit = REG_WDATA[ssr_pkg::DC_SOFT_RESET_BIT];
            r_next.nien = REG_WDATA[ssr_pkg::DC_NIEN];
        end

        // a short soft_reset_bit pulse is ignored; the counter saturates
        if (r_reg.soft_reset_bit) begin
            if (r_reg.soft_reset_bit_cnt != ssr_pkg::SOFT_RESET_BIT_MIN_CNT) begin
                r_next.soft_reset_bit_cnt = r_reg.soft_reset_bit_cnt + 11'h001;
            end
        end else begin
            r_next.soft_reset_bit_cnt = 11'h000;
        end
        soft_go = r_reg.soft_reset_bit && !r_next.soft_reset_bit &&
                  (r_reg.soft_reset_bit_cnt == ssr_pkg::SOFT_RESET_BIT_MIN_CNT);
        link_go = link_sync && !r_reg.link_prev;
        r_next.link_prev = link_sync;

        // command activity only while the sequencer is idle
        if (r_reg.rs == ssr_pkg::RS_RUN) begin
            if (SEEK_START) begin
                r_next.dsc_live = 1'b0;
            end
            if (SEEK_SETTLED) begin
                r_next.dsc_live = 1'b1;
            end
            if (CMD_START) begin
                r_next.err = 1'b0;
                r_next.busy_cmd = 1'b1;
                r_next.hob = 1'b0;
            end
            // error drops ready and freezes seek-complete until status is read
            if (CMD_ERR) begin
                r_next.ready = 1'b0;
                r_next.ready_hold = 1'b1;
                r_next.dsc_hold = 1'b1;
            end
            if (CMD_DONE) begin
                r_next.busy_cmd = 1'b0;
                r_next.err = CMD_FAIL;
                r_next.int_pend = 1'b1;
                if (CMD_FAIL) begin
                    r_next.err_reg = CMD_ERR_CODE;
                end
                // end-of-command address writeback
                r_next.sect_cur = ADDR_LO;
                if (CMD_LBA && CMD_EXT48) begin
                    r_next.sect_prev = ADDR_HI;
                end
            end
            if (PWR_REQ) begin
                r_next.pm = ssr_pkg::ssr_pwr_e'(PWR_REQ_MODE);
            end
            if (DIAG_CMD) begin
                r_next.diag_run = 1'b1;
                r_next.rs = ssr_pkg::RS_DIAG;
            end
        end

        // seek-complete forced while spun down; held still after an error
        if (!r_next.dsc_hold) begin
            r_next.dsc_shown = r_next.dsc_live |
                               (r_next.pm == ssr_pkg::PM_STANDBY) |
                               (r_next.pm == ssr_pkg::PM_SLEEP);
        end

        // ****************************************
        // reset sequencer
        // ****************************************
        case (r_reg.rs)
            ssr_pkg::RS_POR: begin
                // power-on step: init, revert, timer off, choose mode
                r_next.hw_init = 1'b1;
                r_next.tmr_dis = 1'b1;
                r_next.revert = 1'b1;
                r_next.diag_run = 1'b1;
                if (PUIS_STRAP) begin
                    r_next.pm = ssr_pkg::PM_STANDBY;
                end else begin
                    r_next.pm = ssr_pkg::PM_IDLE;
                    r_next.spin_up = 1'b1;
                end
                r_next.rs = ssr_pkg::RS_DIAG;
            end
            ssr_pkg::RS_FLUSH: begin
                // device side aborts only once cached writes are on media
                if (FLUSH_DONE) begin
                    r_next.dev_abort = 1'b1;
                    r_next.revert = REVERT_EN;
                    if (r_reg.pm == ssr_pkg::PM_SLEEP) begin
                        r_next.pm = ssr_pkg::PM_STANDBY;
                    end
                    r_next.diag_run = 1'b1;
                    r_next.rs = ssr_pkg::RS_DIAG;
                end
            end
            ssr_pkg::RS_DIAG: begin
                if (DIAG_DONE) begin
                    case (DIAG_RESULT)
                        3'h1: r_next.err_reg = ssr_pkg::DIAG_FMT;
                        3'h2: r_next.err_reg = ssr_pkg::DIAG_BUF;
                        3'h3: r_next.err_reg = ssr_pkg::DIAG_ECC;
                        3'h4: r_next.err_reg = ssr_pkg::DIAG_CPU;
                        default: r_next.err_reg = ssr_pkg::DIAG_OK;
                    endcase
                    // defaults give status 50h: ready and seek-complete
                    r_next.sect_cur = ssr_pkg::SECT_RST;
                    r_next.sect_prev = ssr_pkg::SECT_RST;
                    r_next.ready = ssr_pkg::STAT_RST[6];
                    r_next.ready_hold = 1'b0;
                    r_next.dsc_live = ssr_pkg::STAT_RST[4];
                    r_next.dsc_shown = ssr_pkg::STAT_RST[4];
                    r_next.dsc_hold = 1'b0;
                    r_next.err = ssr_pkg::STAT_RST[0];
                    r_next.busy_cmd = 1'b0;
                    r_next.int_pend = 1'b1;
                    r_next.load_dflt = 1'b1;
                    r_next.rs = ssr_pkg::RS_RUN;
                end
            end
            ssr_pkg::RS_RUN: begin
            end
            default: begin
                r_next.rs = ssr_pkg::RS_POR;
            end
        endcase

        // link or soft reset restarts the sequence from any step but power-on
        if ((soft_go || link_go) && r_reg.rs != ssr_pkg::RS_POR) begin
            r_next.host_abort = 1'b1;
            r_next.flush_req = 1'b1;
            r_next.diag_run = 1'b0;
            r_next.busy_cmd = 1'b0;
            r_next.rs = ssr_pkg::RS_FLUSH;
        end

        // interrupt line gated by the disable bit
        r_next.intrq = r_next.int_pend & ~r_next.nien;
    end

    // ****************************************
    // state register
    // ****************************************
    // ready stays low from power-up until diagnostics finish
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            r_reg <= '0;
            r_reg.rs <= ssr_pkg::RS_POR;
            r_reg.pm <= ssr_pkg::PM_ACTIVE;
            r_reg.sect_cur <= ssr_pkg::SECT_RST;
            r_reg.sect_prev <= ssr_pkg::SECT_RST;
            r_reg.err_reg <= ssr_pkg::DIAG_OK;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // outputs, all from flops
    // ****************************************
    assign REG_RDATA = r_reg.rdata;
    assign INTRQ = r_reg.intrq;
    assign FLUSH_REQ = r_reg.flush_req;
    assign HOST_ABORT = r_reg.host_abort;
    assign DEV_ABORT = r_reg.dev_abort;
    assign HW_INIT = r_reg.hw_init;
    assign DIAG_RUN = r_reg.diag_run;
    assign TIMER_DISABLE = r_reg.tmr_dis;
    assign PARAM_REVERT = r_reg.revert;
    assign SPIN_UP = r_reg.spin_up;
    assign LOAD_DEFAULTS = r_reg.load_dflt;
    assign PWR_MODE = r_reg.pm;
endmodule
`default_nettype wire

// ===== ssr_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_top_asserts (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_RDATA,
    input wire logic INTRQ,
    input wire logic CMD_DONE,
    input wire logic DIAG_DONE,
    input wire logic FLUSH_DONE,
    input wire logic REVERT_EN,
    input wire logic FLUSH_REQ,
    input wire logic HOST_ABORT,
    input wire logic DEV_ABORT,
    input wire logic HW_INIT,
    input wire logic TIMER_DISABLE,
    input wire logic PARAM_REVERT,
    input wire logic SPIN_UP,
    input wire logic LOAD_DEFAULTS,
    input wire logic [1:0] PWR_MODE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // ****************************************
    // status and interrupt relations
    // ****************************************
    // status reads never show fault or corrected bits
    chk_fault_bits_zero: assert property (
        REG_RD && REG_ADDR == ssr_pkg::RA_STAT |=> REG_RDATA[5] == 1'b0 && REG_RDATA[2] == 1'b0)
        else $error("fault or corrected bit set");
    // a status read drops the interrupt unless one is raised too
    chk_stat_read_ack: assert property (
        REG_RD && REG_ADDR == ssr_pkg::RA_STAT && !CMD_DONE && !DIAG_DONE && !LOAD_DEFAULTS
        |=> !INTRQ)
        else $error("interrupt survived a status read");
    chk_alt_no_ack: assert property (
        INTRQ && REG_RD && !REG_WR && REG_ADDR == ssr_pkg::RA_ALT |=> INTRQ)
        else $error("alternate read dropped interrupt");

    // ****************************************
    // reset sequencing
    // ****************************************
    chk_flush_before_abort: assert property (
        DEV_ABORT |-> $past(FLUSH_DONE))
        else $error("abort before flush done");
    chk_host_abort_pair: assert property (
        FLUSH_REQ |-> HOST_ABORT && !HW_INIT && !TIMER_DISABLE)
        else $error("flush without host abort");
    chk_por_init_set: assert property (
        HW_INIT |-> TIMER_DISABLE && PARAM_REVERT && !HOST_ABORT)
        else $error("power-on pulses incomplete");
    chk_revert_gate: assert property (
        DEV_ABORT |-> PARAM_REVERT == $past(REVERT_EN))
        else $error("revert does not follow setting");
    chk_sleep_to_stby: assert property (
        DEV_ABORT && $past(PWR_MODE) == ssr_pkg::PM_SLEEP
        |-> ##[0:2] PWR_MODE == ssr_pkg::PM_STANDBY)
        else $error("sleep kept on reset");
    chk_defaults_after_diag: assert property (
        LOAD_DEFAULTS |-> $past(DIAG_DONE))
        else $error("defaults before diagnosis");
    chk_spin_idle: assert property (
        SPIN_UP |-> HW_INIT ##1 PWR_MODE == ssr_pkg::PM_IDLE [*2])
        else $error("spin-up did not land in idle");
endmodule
`default_nettype wire

// ===== ssr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_top_bench;
    logic SYS_CLK = 0, RST_N = 0, REG_RD = 0, REG_WR = 0, INTRQ, FLUSH_REQ, HOST_ABORT;
    logic [2:0] REG_ADDR = 3'h0, DIAG_RESULT, diag_code = 3'h0;
    logic [7:0] REG_WDATA = 8'h00, REG_RDATA, CMD_ERR_CODE = 8'h00, ADDR_LO = 8'h00;
    logic [7:0] ADDR_HI = 8'h00, d;
    logic CMD_START = 0, CMD_DONE = 0, CMD_FAIL = 0, CMD_ERR = 0, CMD_LBA = 0, CMD_EXT48 = 0;
    logic SEEK_START = 0, SEEK_SETTLED = 0, DRQ_IN = 0, LINK_RESET = 0, DIAG_CMD = 0;
    logic DIAG_DONE, FLUSH_DONE, REVERT_EN = 0, PWR_REQ = 0, DEV_ABORT, HW_INIT, DIAG_RUN;
    logic [1:0] PWR_REQ_MODE = 2'h0, PWR_MODE;
    logic TIMER_DISABLE, PARAM_REVERT, SPIN_UP, LOAD_DEFAULTS, ld_seen = 0, rev_seen = 0;
    logic INDEX_PIN = 0, PUIS_STRAP = 0;
    int bad_count = 0, n_checks = 0;

    ssr_top u_ssr_top (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_RD(REG_RD), .REG_WR(REG_WR),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .INTRQ(INTRQ),
        .CMD_START(CMD_START), .CMD_DONE(CMD_DONE), .CMD_FAIL(CMD_FAIL),
        .CMD_ERR_CODE(CMD_ERR_CODE), .CMD_ERR(CMD_ERR), .CMD_LBA(CMD_LBA),
        .CMD_EXT48(CMD_EXT48), .ADDR_LO(ADDR_LO), .ADDR_HI(ADDR_HI), .SEEK_START(SEEK_START),
        .SEEK_SETTLED(SEEK_SETTLED), .DRQ_IN(DRQ_IN), .INDEX_PIN(INDEX_PIN),
        .LINK_RESET(LINK_RESET), .DIAG_CMD(DIAG_CMD), .DIAG_DONE(DIAG_DONE),
        .DIAG_RESULT(DIAG_RESULT), .FLUSH_DONE(FLUSH_DONE), .REVERT_EN(REVERT_EN),
        .PUIS_STRAP(PUIS_STRAP), .PWR_REQ(PWR_REQ), .PWR_REQ_MODE(PWR_REQ_MODE),
        .FLUSH_REQ(FLUSH_REQ), .HOST_ABORT(HOST_ABORT), .DEV_ABORT(DEV_ABORT),
        .HW_INIT(HW_INIT), .DIAG_RUN(DIAG_RUN), .TIMER_DISABLE(TIMER_DISABLE),
        .PARAM_REVERT(PARAM_REVERT), .SPIN_UP(SPIN_UP), .LOAD_DEFAULTS(LOAD_DEFAULTS),
        .PWR_MODE(PWR_MODE));
    ssr_backend_model u_ssr_backend_model (.clk(SYS_CLK), .rst_n(RST_N),
        .flush_req(FLUSH_REQ), .diag_run(DIAG_RUN), .diag_code(diag_code),
        .flush_done(FLUSH_DONE), .diag_done(DIAG_DONE), .diag_result(DIAG_RESULT));

    // ****************************************
    // clock, pulse catchers and helpers
    // ****************************************
    initial begin
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    // latch one-cycle pulses for the tasks
    always @(posedge SYS_CLK) begin
        if (LOAD_DEFAULTS) ld_seen = 1;
        if (PARAM_REVERT) rev_seen = 1;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [2:0] a);
        @(negedge SYS_CLK) begin REG_RD = 1; REG_ADDR = a; end
        @(negedge SYS_CLK) REG_RD = 0;
        d = REG_RDATA;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(negedge SYS_CLK) begin REG_WR = 1; REG_ADDR = a; REG_WDATA = v; end
        @(negedge SYS_CLK) REG_WR = 0;
    endtask
    // one-cycle strobe: 0 start, 1 done, 2 error, 3 seek start, 4 settled, 5 diag, 6 power
    task automatic ev(input int w);
        @(negedge SYS_CLK) {PWR_REQ, DIAG_CMD, SEEK_SETTLED, SEEK_START, CMD_ERR, CMD_DONE,
            CMD_START} = 7'(1 << w);
        @(negedge SYS_CLK) {PWR_REQ, DIAG_CMD, SEEK_SETTLED, SEEK_START, CMD_ERR, CMD_DONE,
            CMD_START} = 7'h00;
    endtask
    task automatic wait_ld();
        for (int k = 0; k < 3000 && !ld_seen; k++) @(negedge SYS_CLK);
        chk("defaults_loaded", 8'(ld_seen), 8'h01);
        ld_seen = 0;
        @(negedge SYS_CLK);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_por();
        wait_ld();
        chk("por_mode", 8'(PWR_MODE), 8'(ssr_pkg::PM_IDLE));
        chk("por_irq", 8'(INTRQ), 8'h01);
        rd(ssr_pkg::RA_ALT); chk("alt_stat", d, ssr_pkg::STAT_RST);
        chk("alt_irq", 8'(INTRQ), 8'h01);
        rd(ssr_pkg::RA_STAT); chk("stat", d, ssr_pkg::STAT_RST);
        chk("ack_irq", 8'(INTRQ), 8'h00);
        rd(ssr_pkg::RA_ERROR); chk("diag", d, ssr_pkg::DIAG_OK);
        rd(ssr_pkg::RA_SECT); chk("sect", d, ssr_pkg::SECT_RST);
    endtask
    task automatic t_cmd_fail();
        CMD_FAIL = 1; CMD_ERR_CODE = 8'h04;
        ev(0); rd(ssr_pkg::RA_SECT); chk("busy_any", 8'(d[7]), 8'h01);
        ev(1); CMD_FAIL = 0;
        chk("done_irq", 8'(INTRQ), 8'h01);
        rd(ssr_pkg::RA_ALT); chk("fail_stat", d, 8'h51);
        rd(ssr_pkg::RA_ERROR); chk("fail_code", d, 8'h04);
        ev(0); ev(1); rd(ssr_pkg::RA_STAT); chk("err_clear", d, 8'h50);
    endtask
    task automatic t_err_seek();
        ev(3); rd(ssr_pkg::RA_STAT); chk("seek_go", d, 8'h40);
        ev(4); rd(ssr_pkg::RA_STAT); chk("seek_ok", d, 8'h50);
        CMD_FAIL = 1; CMD_ERR_CODE = 8'h10;
        ev(0); ev(2); ev(3); ev(1); CMD_FAIL = 0;
        rd(ssr_pkg::RA_ALT); chk("frozen", d, 8'h11);
        rd(ssr_pkg::RA_STAT); chk("frozen_rd", d, 8'h11);
        rd(ssr_pkg::RA_STAT); chk("released", d, 8'h41);
        ev(4); DRQ_IN = 1;
        rd(ssr_pkg::RA_STAT); chk("drq_seen", d, 8'h59);
        DRQ_IN = 0;
    endtask
    task automatic t_lba48();
        wr(ssr_pkg::RA_SECT, 8'hA1); wr(ssr_pkg::RA_SECT, 8'hB2);
        rd(ssr_pkg::RA_SECT); chk("sect_new", d, 8'hB2);
        wr(ssr_pkg::RA_DEVCTL, 8'h80);
        rd(ssr_pkg::RA_SECT); chk("sect_old", d, 8'hA1);
        {CMD_LBA, CMD_EXT48, ADDR_LO, ADDR_HI} = {2'b11, 8'h5A, 8'hC3};
        ev(0); ev(1); CMD_LBA = 0; CMD_EXT48 = 0;
        rd(ssr_pkg::RA_SECT); chk("lba_lo", d, 8'h5A);
        wr(ssr_pkg::RA_DEVCTL, 8'h80);
        rd(ssr_pkg::RA_SECT); chk("lba_hi", d, 8'hC3);
        wr(ssr_pkg::RA_DEVCTL, 8'h00);
    endtask
    task automatic t_diag();
        for (int i = 0; i < 5; i++) begin
            diag_code = 3'(i);
            ev(5); wait_ld();
            rd(ssr_pkg::RA_ERROR); chk("diag_code", d, 8'(i + 1));
        end
        diag_code = 3'h0;
    endtask
    task automatic t_soft();
        PWR_REQ_MODE = 2'h3; ev(6);
        chk("sleep", 8'(PWR_MODE), 8'(ssr_pkg::PM_SLEEP));
        REVERT_EN = 1; wr(ssr_pkg::RA_SECT, 8'h77);
        wr(ssr_pkg::RA_DEVCTL, 8'h04);
        repeat (1005) @(negedge SYS_CLK);
        rev_seen = 0; wr(ssr_pkg::RA_DEVCTL, 8'h00); wait_ld();
        chk("revert", 8'(rev_seen), 8'h01);
        chk("stby", 8'(PWR_MODE), 8'(ssr_pkg::PM_STANDBY));
        rd(ssr_pkg::RA_SECT); chk("sect_def", d, ssr_pkg::SECT_RST);
        rd(ssr_pkg::RA_STAT); chk("stat_def", d, ssr_pkg::STAT_RST);
    endtask
    task automatic t_link();
        REVERT_EN = 0; PWR_REQ_MODE = 2'h0; ev(6);
        rev_seen = 0;
        @(negedge SYS_CLK) LINK_RESET = 1;
        wait_ld(); LINK_RESET = 0;
        chk("no_revert", 8'(rev_seen), 8'h00);
        chk("mode_kept", 8'(PWR_MODE), 8'(ssr_pkg::PM_ACTIVE));
        rd(ssr_pkg::RA_ERROR); chk("link_diag", d, ssr_pkg::DIAG_OK);
    endtask
    task automatic t_puis();
        @(negedge SYS_CLK) {RST_N, PUIS_STRAP, INDEX_PIN} = 3'b011;
        @(negedge SYS_CLK) RST_N = 1;
        wait_ld(); ev(3); rd(ssr_pkg::RA_STAT);
        chk("puis", 8'(PWR_MODE), 8'(ssr_pkg::PM_STANDBY));
        chk("idx_dsc", d, 8'h52);
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // the run needs under 5000 cycles; allow six times that
    initial begin
        #150000;
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (5) @(negedge SYS_CLK);
        RST_N = 1;
        t_por(); t_cmd_fail(); t_err_seek(); t_lba48(); t_diag(); t_soft(); t_link(); t_puis();
        wrap_up();
    end
endmodule
bind ssr_top ssr_top_asserts u_ssr_top_asserts (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
    .INTRQ(INTRQ), .CMD_DONE(CMD_DONE), .DIAG_DONE(DIAG_DONE), .FLUSH_DONE(FLUSH_DONE),
    .REVERT_EN(REVERT_EN), .FLUSH_REQ(FLUSH_REQ), .HOST_ABORT(HOST_ABORT),
    .DEV_ABORT(DEV_ABORT), .HW_INIT(HW_INIT), .TIMER_DISABLE(TIMER_DISABLE),
    .PARAM_REVERT(PARAM_REVERT), .SPIN_UP(SPIN_UP), .LOAD_DEFAULTS(LOAD_DEFAULTS),
    .PWR_MODE(PWR_MODE));
`default_nettype wire
